// ---- core/ddr2_cmd_pkg.sv ----
// Purpose: Shared constants for the DDR2 command decode and power-down block.
// Assumes: Single 200 MHz clock, synchronous active-low reset.
// Notes:   Timing counts are in cycles of the core clock.
package ddr2_cmd_pkg;

  // ***********************************************************************
  // Widths and field positions
  // ***********************************************************************
  localparam int BANK_W      = 3;
  localparam int ADDR_W      = 14;
  localparam int MR_W        = 14;
  localparam int PRE_SEL_POS = 10;  // precharge_select_bit position.
  localparam int PDX_SEL_POS = 12;  // powerdown_exit_select_bit position.

  // ***********************************************************************
  // Reset values and timing
  // ***********************************************************************
  localparam logic [MR_W-1:0] MR_RESET = 14'h0000;
  localparam logic [2:0]      BURST_LEN = 3'h4;
  localparam logic [2:0]      BURST_BEATS = 3'h2;  // BL/2 clock cycles.
  localparam logic [7:0]      FAST_EXIT_CYC = 8'h02;
  localparam logic [7:0]      SLOW_EXIT_CYC = 8'h06;
  localparam logic [7:0]      PRE_EXIT_CYC  = 8'h02;
  localparam logic [7:0]      WR_RECOVERY_CYC = 8'h04;

  // ***********************************************************************
  // Decoded commands and device states
  // ***********************************************************************
  typedef enum logic [3:0] {
    CMD_NOP, CMD_MRS, CMD_REFRESH, CMD_SELF_REFRESH, CMD_PRECHARGE,
    CMD_ACTIVATE, CMD_WRITE, CMD_WRITE_AP, CMD_READ, CMD_READ_AP,
    CMD_PD_ENTRY, CMD_PD_EXIT, CMD_SR_EXIT, CMD_ILLEGAL
  } cmd_t;

  typedef enum logic [2:0] {
    ST_IDLE, ST_ACTIVE, ST_PRE_PD, ST_ACT_PD, ST_SELF_REF, ST_EXIT
  } state_t;

endpackage : ddr2_cmd_pkg

// ---- core/ddr2_command_decode_powerdown.sv ----
// Purpose: Decode DDR2 commands and track power-down and self-refresh.
// Assumes: Command pins are synchronous to clock; one edge = one CK edge.
// Notes:   Bank timing, refresh scheduling and ODT timing are not modelled.
// Function
// - CS low, RAS CAS WE high is NOP
// - NOP lets running operations finish
// - CS high is deselect, acts as NOP
// - Active exit latency fast or slow by bit
// - Decode solely from pins and both CKE; here the state also picks self-refresh or power-down exit
// - Bank address picks bank or mode register
// - Burst of four never interrupted
// - No refresh during power-down
// - ODT ignored; unavailable in self-refresh
// - Self-refresh exit on CKE rising, asynchronous; taken here on the first clock edge with CKE high
// - Precharge power-down after explicit or auto precharge
// - Write with auto-precharge encoding
// - Mode register set encoding
// - Power-down entry and exit only with NOP
// - Select bit low fast exit, high slow
`timescale 1ns/1ps
module ddr2_command_decode_powerdown #(
  parameter int NUM_BANKS = 8
) (
  input  wire logic                              clock,
  input  wire logic                              rst_n,
  input  wire logic                              cke,
  input  wire logic                              cs_n,
  input  wire logic                              ras_n,
  input  wire logic                              cas_n,
  input  wire logic                              we_n,
  input  wire logic [ddr2_cmd_pkg::BANK_W-1:0]   bank,
  input  wire logic [ddr2_cmd_pkg::ADDR_W-1:0]   addr,
  input  wire logic                              odt,
  output logic [3:0]                             cmd_ff,
  output logic [ddr2_cmd_pkg::BANK_W-1:0]        cmd_bank_ff,
  output logic                                   auto_precharge_ff,
  output logic [2:0]                             state_ff,
  output logic                                   burst_busy_ff,
  output logic                                   odt_enabled_ff,
  output logic                                   powerdown_exit_select_bit_ff,
  output logic                                   refresh_allowed_ff,
  output logic                                   cmd_ready_ff
);

  // ***********************************************************************
  // Command decode
  // ***********************************************************************
  ddr2_cmd_pkg::cmd_t   nxt_cmd;
  ddr2_cmd_pkg::state_t st;
  logic                 cke_prev_ff;
  logic                 nop_like;
  logic [NUM_BANKS-1:0] open_ff;
  logic [2:0]           burst_cnt_ff;
  logic [7:0]           wait_ff;
  logic [7:0]           ap_cnt_ff;
  logic                 ap_pend_ff;
  logic                 wr_ap;

  assign st = ddr2_cmd_pkg::state_t'(state_ff);
  // Deselect ignores RAS, CAS and WE entirely.
  assign nop_like = cs_n | (ras_n & cas_n & we_n);

  // Only the pins, the two CKE samples and the state feed decode; odt never does.
  always_comb begin
    nxt_cmd = ddr2_cmd_pkg::CMD_ILLEGAL;
    if (!cke_prev_ff && cke) begin
      if (nop_like) begin
        nxt_cmd = (st == ddr2_cmd_pkg::ST_SELF_REF) ?
                  ddr2_cmd_pkg::CMD_SR_EXIT : ddr2_cmd_pkg::CMD_PD_EXIT;
      end
    end else if (!cke_prev_ff) begin
      nxt_cmd = ddr2_cmd_pkg::CMD_NOP;  // Inputs ignored while asleep.
    end else if (!cke) begin
      if (nop_like) begin
        nxt_cmd = ddr2_cmd_pkg::CMD_PD_ENTRY;
      end else if (!ras_n && !cas_n && we_n) begin
        nxt_cmd = ddr2_cmd_pkg::CMD_SELF_REFRESH;
      end
    end else if (nop_like) begin
      nxt_cmd = ddr2_cmd_pkg::CMD_NOP;
    end else begin
      case ({ras_n, cas_n, we_n})
        3'h0: nxt_cmd = ddr2_cmd_pkg::CMD_MRS;
        3'h1: nxt_cmd = ddr2_cmd_pkg::CMD_REFRESH;
        3'h2: nxt_cmd = ddr2_cmd_pkg::CMD_PRECHARGE;
        3'h3: nxt_cmd = ddr2_cmd_pkg::CMD_ACTIVATE;
        3'h4: nxt_cmd = addr[ddr2_cmd_pkg::PRE_SEL_POS] ?
                ddr2_cmd_pkg::CMD_WRITE_AP : ddr2_cmd_pkg::CMD_WRITE;
        3'h5: nxt_cmd = addr[ddr2_cmd_pkg::PRE_SEL_POS] ?
                ddr2_cmd_pkg::CMD_READ_AP : ddr2_cmd_pkg::CMD_READ;
        default: nxt_cmd = ddr2_cmd_pkg::CMD_ILLEGAL;
      endcase
    end
  end

  assign wr_ap = (nxt_cmd == ddr2_cmd_pkg::CMD_WRITE_AP);

  // Register the decoded command and its bank or mode-register select.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      cmd_ff            <= 4'h0;
      cmd_bank_ff       <= '0;
      auto_precharge_ff <= 1'b0;
      cke_prev_ff       <= 1'b0;
    end else begin
      cmd_ff            <= nxt_cmd;
      cmd_bank_ff       <= bank;
      auto_precharge_ff <= addr[ddr2_cmd_pkg::PRE_SEL_POS];
      cke_prev_ff       <= cke;
    end
  end

  // ***********************************************************************
  // Mode register: only the exit select bit steers this block
  // ***********************************************************************
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      powerdown_exit_select_bit_ff <= 1'b0;
    end else if (nxt_cmd == ddr2_cmd_pkg::CMD_MRS && bank == '0) begin
      // Bank selects which mode register; only register 0 is held.
      powerdown_exit_select_bit_ff <=
        addr[ddr2_cmd_pkg::PDX_SEL_POS];
    end
  end

  // ***********************************************************************
  // Burst tracking: a burst of four always runs out
  // ***********************************************************************
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      burst_cnt_ff <= 3'h0;
    end else if (burst_cnt_ff != 3'h0) begin
      burst_cnt_ff <= burst_cnt_ff - 3'h1;
    end else if (nxt_cmd inside {ddr2_cmd_pkg::CMD_WRITE,
                 ddr2_cmd_pkg::CMD_WRITE_AP, ddr2_cmd_pkg::CMD_READ,
                 ddr2_cmd_pkg::CMD_READ_AP}) begin
      burst_cnt_ff <= ddr2_cmd_pkg::BURST_BEATS;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      burst_busy_ff <= 1'b0;
    end else begin
      burst_busy_ff <= (burst_cnt_ff > 3'h1) ||
        (burst_cnt_ff == 3'h0 && nxt_cmd inside {ddr2_cmd_pkg::CMD_WRITE,
         ddr2_cmd_pkg::CMD_WRITE_AP, ddr2_cmd_pkg::CMD_READ,
         ddr2_cmd_pkg::CMD_READ_AP});
    end
  end

  // ***********************************************************************
  // Open banks and the internal precharge after write with auto-precharge
  // ***********************************************************************
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      ap_pend_ff <= 1'b0;
      ap_cnt_ff  <= 8'h00;
    end else if (wr_ap) begin
      ap_pend_ff <= 1'b1;
      ap_cnt_ff  <= ddr2_cmd_pkg::WR_RECOVERY_CYC;
    end else if (ap_pend_ff && ap_cnt_ff != 8'h00) begin
      ap_cnt_ff <= ap_cnt_ff - 8'h01;
    end else begin
      ap_pend_ff <= 1'b0;
    end
  end

  // Each bank row state; a generate loop gives one flop per bank.
  for (genvar b = 0; b < NUM_BANKS; b++) begin : g_bank
    always_ff @(posedge clock) begin
      if (!rst_n) begin
        open_ff[b] <= 1'b0;
      end else if (nxt_cmd == ddr2_cmd_pkg::CMD_ACTIVATE &&
                   bank == ddr2_cmd_pkg::BANK_W'(b)) begin
        open_ff[b] <= 1'b1;
      end else if (nxt_cmd == ddr2_cmd_pkg::CMD_PRECHARGE &&
                   (addr[ddr2_cmd_pkg::PRE_SEL_POS] ||
                    bank == ddr2_cmd_pkg::BANK_W'(b))) begin
        open_ff[b] <= 1'b0;
      end else if ((nxt_cmd == ddr2_cmd_pkg::CMD_READ_AP || wr_ap) &&
                   bank == ddr2_cmd_pkg::BANK_W'(b)) begin
        open_ff[b] <= 1'b0;
      end
    end
  end

  // ***********************************************************************
  // Power state machine
  // ***********************************************************************
  // Self-refresh exit is taken on the first edge that sees CKE high, with
  // no wait for the command pins; true pad-level asynchrony is outside
  // a single-clock core.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      state_ff <= 3'(ddr2_cmd_pkg::ST_IDLE);
      wait_ff  <= 8'h00;
    end else begin
      case (st)
        ddr2_cmd_pkg::ST_IDLE, ddr2_cmd_pkg::ST_ACTIVE: begin
          if (nxt_cmd == ddr2_cmd_pkg::CMD_SELF_REFRESH) begin
            state_ff <= 3'(ddr2_cmd_pkg::ST_SELF_REF);
          end else if (nxt_cmd == ddr2_cmd_pkg::CMD_PD_ENTRY) begin
            // Idle also needs any internal precharge to have finished.
            state_ff <= (open_ff == '0 && !ap_pend_ff) ?
              3'(ddr2_cmd_pkg::ST_PRE_PD) : 3'(ddr2_cmd_pkg::ST_ACT_PD);
          end else begin
            state_ff <= (open_ff == '0) ? 3'(ddr2_cmd_pkg::ST_IDLE) :
                        3'(ddr2_cmd_pkg::ST_ACTIVE);
          end
        end
        ddr2_cmd_pkg::ST_SELF_REF: begin
          if (cke) begin
            state_ff <= 3'(ddr2_cmd_pkg::ST_IDLE);
          end
        end
        ddr2_cmd_pkg::ST_PRE_PD, ddr2_cmd_pkg::ST_ACT_PD: begin
          if (nxt_cmd == ddr2_cmd_pkg::CMD_PD_EXIT) begin
            state_ff <= 3'(ddr2_cmd_pkg::ST_EXIT);
            if (st == ddr2_cmd_pkg::ST_PRE_PD) begin
              wait_ff <= ddr2_cmd_pkg::PRE_EXIT_CYC;
            end else if (powerdown_exit_select_bit_ff) begin
              wait_ff <= ddr2_cmd_pkg::SLOW_EXIT_CYC;
            end else begin
              wait_ff <= ddr2_cmd_pkg::FAST_EXIT_CYC;
            end
          end
        end
        ddr2_cmd_pkg::ST_EXIT: begin
          if (wait_ff <= 8'h01) begin
            state_ff <= (open_ff == '0) ? 3'(ddr2_cmd_pkg::ST_IDLE) :
                        3'(ddr2_cmd_pkg::ST_ACTIVE);
            wait_ff  <= 8'h00;
          end else begin
            wait_ff <= wait_ff - 8'h01;
          end
        end
        default: state_ff <= 3'(ddr2_cmd_pkg::ST_IDLE);
      endcase
    end
  end

  // ***********************************************************************
  // Status outputs
  // ***********************************************************************
  // Refresh is never performed while asleep in power-down.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      refresh_allowed_ff <= 1'b1;
      odt_enabled_ff     <= 1'b0;
      cmd_ready_ff       <= 1'b1;
    end else begin
      refresh_allowed_ff <= !(st == ddr2_cmd_pkg::ST_PRE_PD ||
                              st == ddr2_cmd_pkg::ST_ACT_PD);
      odt_enabled_ff <= odt && st != ddr2_cmd_pkg::ST_SELF_REF;
      cmd_ready_ff   <= st == ddr2_cmd_pkg::ST_IDLE ||
                        st == ddr2_cmd_pkg::ST_ACTIVE;
    end
  end

  // ***********************************************************************
  // Checks
  // ***********************************************************************
  chk_nop_decode: assert property (@(posedge clock) disable iff (!rst_n)
    cke_prev_ff && cke && nop_like |=> cmd_ff == 4'(ddr2_cmd_pkg::CMD_NOP))
    else $error("nop not decoded");
  chk_burst_runs_out: assert property (@(posedge clock) disable iff (!rst_n)
    burst_cnt_ff == 3'h2 |=> burst_cnt_ff == 3'h1 ##1 burst_cnt_ff == 3'h0)
    else $error("burst cut short");
  chk_sr_exit: assert property (@(posedge clock) disable iff (!rst_n)
    st == ddr2_cmd_pkg::ST_SELF_REF && cke |=>
    state_ff == 3'(ddr2_cmd_pkg::ST_IDLE))
    else $error("self refresh exit missed");
  chk_slow_exit: assert property (@(posedge clock) disable iff (!rst_n)
    st == ddr2_cmd_pkg::ST_ACT_PD && nxt_cmd == ddr2_cmd_pkg::CMD_PD_EXIT
    && powerdown_exit_select_bit_ff |=> wait_ff == 8'h06)
    else $error("slow exit latency wrong");
  chk_fast_exit: assert property (@(posedge clock) disable iff (!rst_n)
    st == ddr2_cmd_pkg::ST_ACT_PD && nxt_cmd == ddr2_cmd_pkg::CMD_PD_EXIT
    && !powerdown_exit_select_bit_ff |=> wait_ff == 8'h02)
    else $error("fast exit latency wrong");
  chk_no_refresh_pd: assert property (@(posedge clock) disable iff (!rst_n)
    st == ddr2_cmd_pkg::ST_PRE_PD |=> !refresh_allowed_ff)
    else $error("refresh allowed in power down");
  chk_wr_ap_decode: assert property (@(posedge clock) disable iff (!rst_n)
    cke_prev_ff && cke && !cs_n && ras_n && !cas_n && !we_n
    && addr[10] |=> cmd_ff == 4'(ddr2_cmd_pkg::CMD_WRITE_AP) &&
    auto_precharge_ff)
    else $error("write auto precharge wrong");
  chk_odt_in_sr: assert property (@(posedge clock) disable iff (!rst_n)
    st == ddr2_cmd_pkg::ST_SELF_REF |=> !odt_enabled_ff)
    else $error("odt on in self refresh");
  cov_sr: cover property (@(posedge clock) st == ddr2_cmd_pkg::ST_SELF_REF);
  cov_act_pd: cover property (@(posedge clock) st == ddr2_cmd_pkg::ST_ACT_PD);
  cov_pre_pd: cover property (@(posedge clock) st == ddr2_cmd_pkg::ST_PRE_PD);

endmodule : ddr2_command_decode_powerdown

// ---- testbench/ddr2_command_decode_powerdown_tb.sv ----
// Purpose: Self-checking bench for the command decode and power-down block.
// Assumes: Outputs answer on the edge that samples the pins, one cycle after they are driven.
// Notes:   Active power-down exit latencies are compared against the package constants.
`timescale 1ns/1ps
module ddr2_command_decode_powerdown_tb;
  // ***********************************************************************
  // Signals and stimulus table
  // ***********************************************************************
  localparam logic [3:0] P_NOP = 4'h7;
  localparam logic [3:0] P_MRS = 4'h0;
  localparam logic [3:0] P_REF = 4'h1;
  localparam logic [3:0] P_PRE = 4'h2;
  localparam logic [3:0] P_ACT = 4'h3;
  localparam logic [3:0] P_WR  = 4'h4;
  localparam logic [3:0] P_RD  = 4'h5;
  localparam int         NROWS = 12;
  // Row: pins, bank, addr, expected command, expected auto-precharge.
  localparam logic [25:0] ROWS [NROWS] = '{
    {P_NOP, 3'h0, 14'h3FFF, 4'h0, 1'h0},
    {4'h8,  3'h0, 14'h0000, 4'h0, 1'h0},
    {P_MRS, 3'h0, 14'h0000, 4'h1, 1'h0},
    {P_MRS, 3'h3, 14'h0004, 4'h1, 1'h0},
    {P_ACT, 3'h5, 14'h0123, 4'h5, 1'h0},
    {P_WR,  3'h5, 14'h0000, 4'h6, 1'h0},
    {P_NOP, 3'h0, 14'h0000, 4'h0, 1'h0},
    {P_WR,  3'h6, 14'h0400, 4'h7, 1'h1},
    {P_RD,  3'h2, 14'h0000, 4'h8, 1'h0},
    {P_RD,  3'h7, 14'h0400, 4'h9, 1'h1},
    {P_PRE, 3'h4, 14'h0000, 4'h4, 1'h0},
    {P_REF, 3'h0, 14'h0000, 4'h2, 1'h0}
  };
  logic        clock = 1'h0;
  logic        rst_n = 1'h0;
  logic        odt_req = 1'h0;
  logic [25:0] r;
  int          errors = 0;
  int          n_compared = 0;
  wire logic cke, cs_n, ras_n, cas_n, we_n, odt;
  wire logic [2:0]  bank;
  wire logic [13:0] addr;
  logic [3:0] cmd_ff;
  logic [2:0] cmd_bank_ff, state_ff;
  logic auto_precharge_ff, burst_busy_ff, odt_enabled_ff;
  logic powerdown_exit_select_bit_ff, refresh_allowed_ff, cmd_ready_ff;

  // The rate never changes, so no frequency change is ever attempted.
  always #2.5 clock = ~clock;

  ddr2_ctrl_model ctrl_u (.clock(clock), .cke(cke), .cs_n(cs_n),
    .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .bank(bank), .addr(addr),
    .odt(odt));

  ddr2_command_decode_powerdown dut_u (.clock(clock), .rst_n(rst_n),
    .cke(cke), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n),
    .bank(bank), .addr(addr), .odt(odt), .cmd_ff(cmd_ff),
    .cmd_bank_ff(cmd_bank_ff), .auto_precharge_ff(auto_precharge_ff),
    .state_ff(state_ff), .burst_busy_ff(burst_busy_ff),
    .odt_enabled_ff(odt_enabled_ff),
    .powerdown_exit_select_bit_ff(powerdown_exit_select_bit_ff),
    .refresh_allowed_ff(refresh_allowed_ff), .cmd_ready_ff(cmd_ready_ff));

  // ***********************************************************************
  // Tasks
  // ***********************************************************************
  task check(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  // Each call shows the result of the command sent by the previous call.
  task go(input logic [3:0] p, input logic k, input logic [2:0] b,
          input logic [13:0] a);
    ctrl_u.send(p, k, b, a, odt_req);
    #1;
  endtask : go

  task nop(input logic k);
    go(P_NOP, k, 3'h0, 14'h0000);
  endtask : nop

  // Active power-down round trip; the exit wait is counted in cycles.
  task act_pd(input logic [7:0] lat);
    int n;
    n = 0;
    go(P_ACT, 1'h1, 3'h1, 14'h0010);
    nop(1'h1);
    nop(1'h0);
    check(state_ff, 16'h1);
    nop(1'h0);
    check(cmd_ff, 16'hA);
    check(state_ff, 16'h3);
    nop(1'h0);
    check(refresh_allowed_ff, 16'h0);
    nop(1'h0);
    nop(1'h1);
    nop(1'h1);
    check(cmd_ff, 16'hB);
    while (state_ff === 3'h5 && n < 20) begin
      nop(1'h1);
      n++;
    end
    check(16'(n), {8'h00, lat});
    check(state_ff, 16'h1);
    go(P_PRE, 1'h1, 3'h0, 14'h0400);
  endtask : act_pd

  task end_sim;
    $display("compared=%0d errors=%0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : end_sim

  // ***********************************************************************
  // Main sequence
  // ***********************************************************************
  initial begin
    repeat (4) @(posedge clock);
    rst_n <= 1'h1;
    #1;
    check({refresh_allowed_ff, cmd_ready_ff, state_ff}, 16'h18);
    repeat (4) nop(1'h1);
    // Table rows run back to back.
    for (int i = 0; i <= NROWS; i++) begin
      if (i < NROWS) go(ROWS[i][25:22], 1'h1, ROWS[i][21:19], ROWS[i][18:5]);
      else nop(1'h1);
      if (i > 0) begin
        r = ROWS[i-1];
        check(cmd_ff, 16'(r[4:1]));
        if (r[4:1] != 4'h0) check(cmd_bank_ff, 16'(r[21:19]));
        if (r[4:1] >= 4'h6) check(auto_precharge_ff, 16'(r[0]));
      end
    end
    // A burst of four keeps running through NOPs.
    go(P_ACT, 1'h1, 3'h0, 14'h0000);
    go(P_WR, 1'h1, 3'h0, 14'h0000);
    nop(1'h1);
    check(burst_busy_ff, 16'h1);
    nop(1'h1);
    check(burst_busy_ff, 16'h1);
    nop(1'h1);
    check(burst_busy_ff, 16'h0);
    go(P_PRE, 1'h1, 3'h0, 14'h0400);
    go(P_MRS, 1'h1, 3'h0, 14'h0000);
    nop(1'h1);
    check(powerdown_exit_select_bit_ff, 16'h0);
    act_pd(ddr2_cmd_pkg::FAST_EXIT_CYC);
    go(P_MRS, 1'h1, 3'h0, 14'h1000);
    go(P_MRS, 1'h1, 3'h2, 14'h0000);
    nop(1'h1);
    check(powerdown_exit_select_bit_ff, 16'h1);
    act_pd(ddr2_cmd_pkg::SLOW_EXIT_CYC);
    // Entry with a non-NOP command is refused.
    go(P_ACT, 1'h1, 3'h1, 14'h0000);
    go(P_ACT, 1'h0, 3'h2, 14'h0000);
    nop(1'h0);
    check(cmd_ff, 16'hD);
    check(state_ff, 16'h1);
    nop(1'h0);
    repeat (4) nop(1'h1);
    go(P_PRE, 1'h1, 3'h0, 14'h0400);
    // Write with auto-precharge, then precharge power-down.
    go(P_ACT, 1'h1, 3'h2, 14'h0000);
    go(P_WR, 1'h1, 3'h2, 14'h0400);
    repeat (10) nop(1'h1);
    nop(1'h0);
    nop(1'h0);
    check(state_ff, 16'h2);
    repeat (2) nop(1'h0);
    repeat (10) nop(1'h1);
    check(state_ff, 16'h0);
    // Self-refresh with termination requested.
    odt_req = 1'h1;
    go(P_REF, 1'h0, 3'h0, 14'h0000);
    nop(1'h0);
    check(state_ff, 16'h4);
    nop(1'h0);
    check(odt_enabled_ff, 16'h0);
    check(cmd_ready_ff, 16'h0);
    nop(1'h1);
    nop(1'h1);
    check(cmd_ff, 16'hC);
    nop(1'h1);
    check(state_ff, 16'h0);
    odt_req = 1'h0;
    end_sim();
  end

  // The sequence needs about a hundred cycles; this cuts a hang short.
  initial begin
    repeat (3000) @(posedge clock);
    errors++;
    end_sim();
  end
endmodule : ddr2_command_decode_powerdown_tb

// ---- testbench/ddr2_ctrl_model.sv ----
// Purpose: Behavioural memory controller that drives the command pins.
// Assumes: Pins change by non-blocking assignment just after a rising edge.
// Notes:   Callers keep every CKE level for at least three edges.
`timescale 1ns/1ps
module ddr2_ctrl_model (
  input  wire logic                            clock,
  output logic                                 cke,
  output logic                                 cs_n,
  output logic                                 ras_n,
  output logic                                 cas_n,
  output logic                                 we_n,
  output logic [ddr2_cmd_pkg::BANK_W-1:0]      bank,
  output logic [ddr2_cmd_pkg::ADDR_W-1:0]      addr,
  output logic                                 odt
);
  // Idle pins show a NOP, with don't-care pins at a defined level.
  initial begin
    cke = 1'h0;
    {cs_n, ras_n, cas_n, we_n} = 4'h7;
    bank = 3'h0;
    addr = 14'h0000;
    odt = 1'h0;
  end

  // One command a cycle; it stands until the next call moves the pins.
  task send(input logic [3:0] pins, input logic k, input logic [2:0] b,
            input logic [13:0] a, input logic o);
    @(posedge clock);
    {cs_n, ras_n, cas_n, we_n} <= pins;
    cke <= k;
    bank <= b;
    addr <= a;
    odt <= o;
  endtask : send
endmodule : ddr2_ctrl_model
